//--- logic/fieldbus_pkg.sv
// Shared constants and types for the fieldbus slave state machine and its master end.
package fieldbus_pkg;
   // Station address range and reserved addresses.
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam logic [6:0] ADDR_MIN = 7'h00;
   localparam logic [6:0] ADDR_MAX = 7'h7F;
   localparam logic [6:0] ADDR_LAST_ASSIGNABLE = 7'h7D;
   localparam logic [6:0] ADDR_SOFT = 7'h7E;
   localparam logic [6:0] ADDR_BCAST = 7'h7F;
   // Request commands carried on the link.
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_SET_ADDR = 3'h1,
      CMD_PRM = 3'h2,
      CMD_CFG = 3'h3,
      CMD_DIAG = 3'h4,
      CMD_DATA = 3'h5
   } cmd_t;
   // Slave communication states, Gray coded along the start-up path.
   typedef enum logic [1:0] {
      ST_POR = 2'b00,
      ST_WAIT_PRM = 2'b01,
      ST_WAIT_CFG = 2'b11,
      ST_DATA_EXCH = 2'b10
   } dx_state_t;
   // Master end states.
   typedef enum logic {
      M_IDLE = 1'b0,
      M_WAIT = 1'b1
   } mst_state_t;
   // Field positions of a parameter request payload.
   localparam int PRM_F1_LSB = 8;
   localparam int PRM_F2_LSB = 0;
   localparam int FACTOR_W = 8;
   // Field positions of a diagnosis answer.
   localparam int DIAG_ADDR_LSB = 0;
   localparam int DIAG_STATE_LSB = 8;
   localparam int DIAG_SAFE_BIT = 10;
   // Reset values.
   localparam logic [15:0] RST_OUT_DATA = 16'h0000;
   localparam logic [7:0] RST_FACTOR = 8'h00;
   // Timing.
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int WD_BASE_SHORT_MS = 1;
   localparam int WD_BASE_LONG_MS = 10;
   localparam int RSP_TIMEOUT_US = 100;
   localparam int RSP_TIMEOUT_CYCLES = RSP_TIMEOUT_US * (CLK_HZ / 1_000_000);
endpackage : fieldbus_pkg

//--- logic/fieldbus_if.sv
// Link between the bus master end and the slave communication layer.
`timescale 1ns/1ps
`default_nettype none
interface fieldbus_if;
   import fieldbus_pkg::*;
   logic req_valid;
   cmd_t req_cmd;
   logic [6:0] req_addr;
   logic [15:0] req_data;
   logic req_flag;
   logic rsp_valid;
   logic rsp_ok;
   logic [15:0] rsp_data;
   modport dev (
      input req_valid, req_cmd, req_addr, req_data, req_flag,
      output rsp_valid, rsp_ok, rsp_data
   );
   modport mst (
      output req_valid, req_cmd, req_addr, req_data, req_flag,
      input rsp_valid, rsp_ok, rsp_data
   );
endinterface : fieldbus_if
`default_nettype wire

//--- logic/fieldbus_slave.sv
// Slave communication layer: start-up state sequence, address checks and response watchdog.
//
// Behaviour
// RULE1 - Obtain station address before waiting for parameters.
// RULE2 - Parametrization success moves to wait-for-configuration.
// RULE3 - Configuration success moves to data exchange.
// RULE4 - Cyclic exchange only after parametrization and configuration.
// RULE5 - Station addresses limited to zero through 127.
// RULE6 - Address 126 marks slave awaiting soft addressing.
// RULE7 - Address 127 broadcast accepted by every slave.
// RULE8 - Watchdog restarts on every master request.
// RULE9 - Watchdog expiry drives outputs fail-safe.
// RULE10 - Watchdog from 1/10 ms base, two factors.
// RULE11 - Watchdog loaded from run-up parameters.
// RULE12 - Start-up parameters fixed until next start-up.
// RULE13 - Period equals base times both factors.
// RULE14 - Expiry returns slave to wait-for-parameters.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave
   import fieldbus_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES,
   parameter logic [15:0] FAILSAFE_DATA = 16'h0000
) (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // Link to the master
   fieldbus_if.dev BUS,
   // Station setup
   input wire logic [6:0] ADDR_STRAP_I,
   input wire logic [15:0] CFG_EXPECT_I,
   // Process data
   input wire logic [15:0] IN_DATA_I,
   output logic [15:0] OUT_DATA_O,
   output logic OUT_SAFE_O,
   // Status
   output logic [1:0] STATE_O,
   output logic [6:0] STATION_ADDR_O,
   output logic WD_EXPIRED_O
);
   dx_state_t state;
   dx_state_t next_state;
   logic started;
   logic [6:0] station;
   logic wd_long;
   logic [7:0] factor1;
   logic [7:0] factor2;
   logic [31:0] ms_cnt;
   logic [3:0] base_cnt;
   logic [15:0] wd_cnt;
   logic [15:0] wd_limit;
   logic [3:0] base_last;
   logic ms_tick;
   logic unit_tick;
   logic wd_run;
   logic expire;
   logic hit;
   logic bcast;
   logic accept;
   logic do_addr;
   logic do_prm;
   logic do_data;
   logic [7:0] req_f1;
   logic [7:0] req_f2;

   assign req_f1 = BUS.req_data[PRM_F1_LSB +: FACTOR_W];
   assign req_f2 = BUS.req_data[PRM_F2_LSB +: FACTOR_W];
   // RULE7 - broadcast address match
   assign bcast = (BUS.req_addr == ADDR_BCAST);
   assign hit = BUS.req_valid && started && ((BUS.req_addr == station) || bcast);

   // Request decoding and state sequencing.
   always_comb begin
      next_state = state;
      accept = 1'b0;
      do_addr = 1'b0;
      do_prm = 1'b0;
      do_data = 1'b0;
      if (hit) begin
         case (BUS.req_cmd)
            CMD_SET_ADDR: begin
               // RULE5 - assignable address range
               // RULE6 - soft address only
               if (state == ST_POR && !bcast && station == ADDR_SOFT &&
                   BUS.req_data[6:0] <= ADDR_LAST_ASSIGNABLE) begin
                  accept = 1'b1;
                  do_addr = 1'b1;
                  // RULE1 - address then parameters
                  next_state = ST_WAIT_PRM;
               end
            end
            CMD_PRM: begin
               // RULE12 - parameters only once
               // RULE2 - parametrization to configuration
               if (state == ST_WAIT_PRM && req_f1 != RST_FACTOR && req_f2 != RST_FACTOR) begin
                  accept = 1'b1;
                  do_prm = 1'b1;
                  next_state = ST_WAIT_CFG;
               end
            end
            CMD_CFG: begin
               // RULE3 - configuration to exchange
               if (state == ST_WAIT_CFG && BUS.req_data == CFG_EXPECT_I) begin
                  accept = 1'b1;
                  next_state = ST_DATA_EXCH;
               end
            end
            CMD_DIAG: begin
               accept = (state != ST_POR);
            end
            CMD_DATA: begin
               // RULE4 - exchange only when configured
               if (state == ST_DATA_EXCH) begin
                  accept = 1'b1;
                  do_data = 1'b1;
               end
            end
            default: begin
               accept = 1'b0;
            end
         endcase
      end
      // RULE14 - expiry back to parameters
      if (expire) begin
         next_state = ST_WAIT_PRM;
      end
   end

   // A strapped address below the soft address skips soft addressing.
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= ST_POR;
         started <= 1'b0;
         station <= ADDR_SOFT;
      end else if (!started) begin
         started <= 1'b1;
         // RULE5 - strap range check
         if (ADDR_STRAP_I <= ADDR_LAST_ASSIGNABLE) begin
            station <= ADDR_STRAP_I;
            // RULE1 - hard address obtained
            state <= ST_WAIT_PRM;
         end else begin
            station <= ADDR_SOFT;
         end
      end else begin
         state <= next_state;
         if (do_addr) begin
            station <= BUS.req_data[6:0];
         end
      end
   end

   // RULE11 - load watchdog parameters
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wd_long <= 1'b0;
         factor1 <= RST_FACTOR;
         factor2 <= RST_FACTOR;
      end else if (do_prm) begin
         wd_long <= BUS.req_flag;
         factor1 <= req_f1;
         factor2 <= req_f2;
      end
   end

   // Watchdog prescaler chain: device clock to milliseconds to time base units.
   // RULE10 - selectable time base
   assign base_last = wd_long ? 4'(WD_BASE_LONG_MS - 1) : 4'(WD_BASE_SHORT_MS - 1);
   // RULE13 - base times both factors
   assign wd_limit = factor1 * factor2;
   assign wd_run = (state == ST_WAIT_CFG) || (state == ST_DATA_EXCH);
   assign ms_tick = (ms_cnt == 32'(MS_CYC - 1));
   assign unit_tick = ms_tick && (base_cnt == base_last);
   // Restart wins over expiry, so a request in the last cycle still saves the outputs.
   assign expire = wd_run && !hit && unit_tick && (wd_cnt == wd_limit - 16'h0001);

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ms_cnt <= '0;
         base_cnt <= '0;
         wd_cnt <= '0;
      end else if (hit || !wd_run || expire) begin
         // RULE8 - restart on request
         ms_cnt <= '0;
         base_cnt <= '0;
         wd_cnt <= '0;
      end else if (ms_tick) begin
         ms_cnt <= '0;
         if (unit_tick) begin
            base_cnt <= '0;
            wd_cnt <= wd_cnt + 16'h0001;
         end else begin
            base_cnt <= base_cnt + 4'h1;
         end
      end else begin
         ms_cnt <= ms_cnt + 32'h0000_0001;
      end
   end

   // OUT_SAFE_O stays set until the first data exchange delivers real values; OUT_DATA_O holds RST_OUT_DATA until then, or FAILSAFE_DATA after an expiry.
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         OUT_DATA_O <= RST_OUT_DATA;
         OUT_SAFE_O <= 1'b1;
         WD_EXPIRED_O <= 1'b0;
      end else begin
         WD_EXPIRED_O <= expire;
         if (expire) begin
            // RULE9 - fail-safe on expiry
            OUT_DATA_O <= FAILSAFE_DATA;
            OUT_SAFE_O <= 1'b1;
         end else if (do_data) begin
            OUT_DATA_O <= BUS.req_data;
            OUT_SAFE_O <= 1'b0;
         end
      end
   end

   // Answers; a broadcast is acted on but never answered, to avoid collisions.
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         BUS.rsp_valid <= 1'b0;
         BUS.rsp_ok <= 1'b0;
         BUS.rsp_data <= 16'h0000;
      end else begin
         BUS.rsp_valid <= hit && !bcast;
         BUS.rsp_ok <= accept;
         if (hit && BUS.req_cmd == CMD_DATA && accept) begin
            BUS.rsp_data <= IN_DATA_I;
         end else begin
            BUS.rsp_data <= 16'h0000;
            BUS.rsp_data[DIAG_ADDR_LSB +: ADDR_W] <= station;
            BUS.rsp_data[DIAG_STATE_LSB +: 2] <= state;
            BUS.rsp_data[DIAG_SAFE_BIT] <= OUT_SAFE_O;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         STATE_O <= ST_POR;
         STATION_ADDR_O <= ADDR_SOFT;
      end else begin
         STATE_O <= state;
         STATION_ADDR_O <= station;
      end
   end
endmodule : fieldbus_slave
`default_nettype wire

//--- logic/fieldbus_master.sv
// Bus master end: issues one request at a time and waits for the slave's answer or a timeout; a broadcast completes without waiting.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master
   import fieldbus_pkg::*;
#(
   parameter int RSP_TIMEOUT = RSP_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // Link to the slave
   fieldbus_if.mst BUS,
   // Command from the user
   input wire logic CMD_VALID_I,
   input wire logic [2:0] CMD_I,
   input wire logic [6:0] CMD_ADDR_I,
   input wire logic [15:0] CMD_DATA_I,
   input wire logic CMD_FLAG_I,
   output logic CMD_READY_O,
   // Result to the user
   output logic DONE_O,
   output logic DONE_OK_O,
   output logic DONE_TIMEOUT_O,
   output logic [15:0] DONE_DATA_O
);
   mst_state_t state;
   logic is_bcast;
   logic [15:0] timer;
   logic take;

   assign take = CMD_VALID_I && CMD_READY_O && (state == M_IDLE);

   // Request drive; a station address above the range cannot be formed with seven bits.
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         BUS.req_valid <= 1'b0;
         BUS.req_cmd <= CMD_NONE;
         BUS.req_addr <= ADDR_MIN;
         BUS.req_data <= 16'h0000;
         BUS.req_flag <= 1'b0;
      end else begin
         BUS.req_valid <= take;
         if (take) begin
            BUS.req_cmd <= cmd_t'(CMD_I);
            BUS.req_addr <= CMD_ADDR_I;
            BUS.req_data <= CMD_DATA_I;
            // RULE11 - time base select
            BUS.req_flag <= CMD_FLAG_I;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= M_IDLE;
         is_bcast <= 1'b0;
         timer <= 16'h0000;
         CMD_READY_O <= 1'b1;
         DONE_O <= 1'b0;
         DONE_OK_O <= 1'b0;
         DONE_TIMEOUT_O <= 1'b0;
         DONE_DATA_O <= 16'h0000;
      end else begin
         DONE_O <= 1'b0;
         case (state)
            M_IDLE: begin
               if (take) begin
                  state <= M_WAIT;
                  CMD_READY_O <= 1'b0;
                  // RULE7 - broadcast gets no answer
                  is_bcast <= (CMD_ADDR_I == ADDR_BCAST);
                  timer <= 16'(RSP_TIMEOUT - 1);
               end
            end
            M_WAIT: begin
               if (is_bcast) begin
                  state <= M_IDLE;
                  CMD_READY_O <= 1'b1;
                  DONE_O <= 1'b1;
                  DONE_OK_O <= 1'b1;
                  DONE_TIMEOUT_O <= 1'b0;
                  DONE_DATA_O <= 16'h0000;
               end else if (BUS.rsp_valid) begin
                  state <= M_IDLE;
                  CMD_READY_O <= 1'b1;
                  DONE_O <= 1'b1;
                  DONE_OK_O <= BUS.rsp_ok;
                  DONE_TIMEOUT_O <= 1'b0;
                  DONE_DATA_O <= BUS.rsp_data;
               end else if (timer == 16'h0000) begin
                  state <= M_IDLE;
                  CMD_READY_O <= 1'b1;
                  DONE_O <= 1'b1;
                  DONE_OK_O <= 1'b0;
                  DONE_TIMEOUT_O <= 1'b1;
                  DONE_DATA_O <= 16'h0000;
               end else begin
                  timer <= timer - 16'h0001;
               end
            end
            default: begin
               state <= M_IDLE;
               CMD_READY_O <= 1'b1;
            end
         endcase
      end
   end
endmodule : fieldbus_master
`default_nettype wire

//--- test/fieldbus_assertions.sv
// Link checker between the master end and the slave.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_assertions
   import fieldbus_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // Link signals
   input wire logic req_valid,
   input wire cmd_t req_cmd,
   input wire logic [6:0] req_addr,
   input wire logic [15:0] req_data,
   input wire logic req_flag,
   input wire logic rsp_valid,
   input wire logic rsp_ok,
   input wire logic [15:0] rsp_data
);
   logic ack;
   logic prm_seen;
   logic cfg_seen;
   assign ack = rsp_valid && rsp_ok;
   // Sticky flags stay set across a watchdog fall-back, which only loosens the order checks.
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         prm_seen <= 1'b0;
         cfg_seen <= 1'b0;
      end else begin
         if (ack && $past(req_cmd) == CMD_PRM) prm_seen <= 1'b1;
         if (ack && $past(req_cmd) == CMD_CFG) cfg_seen <= 1'b1;
      end
   end
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   rsp_timing_a: assert property (rsp_valid |-> $past(req_valid))
      else $error("Answer without a request one cycle before.");
   req_pulse_a: assert property (req_valid |=> !req_valid)
      else $error("Request held longer than one cycle.");
   bcast_silent_a: assert property (req_valid && req_addr == ADDR_BCAST |=> !rsp_valid)
      else $error("Broadcast request was answered.");
   addr_range_a: assert property (ack && $past(req_cmd) == CMD_SET_ADDR
      |-> $past(req_data[6:0]) <= ADDR_LAST_ASSIGNABLE)
      else $error("Address outside the assignable range accepted.");
   soft_addr_a: assert property (ack && $past(req_cmd) == CMD_SET_ADDR
      |-> $past(req_addr) == ADDR_SOFT)
      else $error("Address set on a station that was not soft.");
   prm_factor_a: assert property (ack && $past(req_cmd) == CMD_PRM
      |-> $past(req_data[15:8]) != 8'h00 && $past(req_data[7:0]) != 8'h00)
      else $error("Parameters with a zero factor accepted.");
   cfg_order_a: assert property (ack && $past(req_cmd) == CMD_CFG |-> prm_seen)
      else $error("Configuration accepted before parameters.");
   data_order_a: assert property (ack && $past(req_cmd) == CMD_DATA |-> cfg_seen)
      else $error("Data accepted before configuration.");
   cov_addr_c: cover property (ack && $past(req_cmd) == CMD_SET_ADDR);
   cov_data_c: cover property (ack && $past(req_cmd) == CMD_DATA);
   cov_refuse_c: cover property (rsp_valid && !rsp_ok);
endmodule : fieldbus_assertions
`default_nettype wire

//--- test/fieldbus_slave_state_watchdog_tb.sv
// Testbench joining the master end and the slave through the link.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_state_watchdog_tb;
   import fieldbus_pkg::*;
   localparam int MSC = 4;
   localparam logic [15:0] FS = 16'hA5A5;
   localparam logic [6:0] SA = 7'h7D;
   logic clk, rst_n, cv, cf, rdy, done, dok, dto, safe, wde, fl;
   logic [2:0] cmd;
   logic [6:0] ca, strap, sta;
   logic [15:0] cd, ddat, cexp, ind, outd, d;
   logic [1:0] st;
   logic [7:0] f1, f2;
   int seed, n_errors, comparisons, per, k, nwd, snap;
   fieldbus_if bus ();
   fieldbus_slave #(.MS_CYC(MSC), .FAILSAFE_DATA(FS)) u_fieldbus_slave (.SYS_CLK_I(clk),
      .RST_N_I(rst_n), .BUS(bus.dev), .ADDR_STRAP_I(strap), .CFG_EXPECT_I(cexp),
      .IN_DATA_I(ind), .OUT_DATA_O(outd), .OUT_SAFE_O(safe), .STATE_O(st),
      .STATION_ADDR_O(sta), .WD_EXPIRED_O(wde));
   fieldbus_master #(.RSP_TIMEOUT(20)) u_fieldbus_master (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .BUS(bus.mst), .CMD_VALID_I(cv), .CMD_I(cmd), .CMD_ADDR_I(ca), .CMD_DATA_I(cd),
      .CMD_FLAG_I(cf), .CMD_READY_O(rdy), .DONE_O(done), .DONE_OK_O(dok),
      .DONE_TIMEOUT_O(dto), .DONE_DATA_O(ddat));
   fieldbus_assertions u_fieldbus_assertions (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .req_valid(bus.req_valid), .req_cmd(bus.req_cmd), .req_addr(bus.req_addr),
      .req_data(bus.req_data), .req_flag(bus.req_flag), .rsp_valid(bus.rsp_valid),
      .rsp_ok(bus.rsp_ok), .rsp_data(bus.rsp_data));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wde === 1'b1) nwd++;
   end
   task automatic stop_test;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One command through the master; the master is idle whenever this is entered.
   task automatic go(input logic [2:0] c, input logic [6:0] a, input logic [15:0] v,
                     input logic f);
      int i;
      @(negedge clk);
      cv = 1'b1;
      cmd = c;
      ca = a;
      cd = v;
      cf = f;
      @(negedge clk);
      cv = 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 40) begin
         @(negedge clk);
         i++;
      end
      if (i == 40) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, done, 1'b1);
      end
   endtask : go
   function automatic logic [15:0] diag_w(input logic [1:0] s, input logic sf);
      return {5'h00, sf, s, 1'b0, SA};
   endfunction : diag_w
   function automatic int wd_per(input logic b, input logic [7:0] x, input logic [7:0] y);
      return (b ? 10 : 1) * x * y * MSC;
   endfunction : wd_per
   initial begin
      #1_000_000;
      n_errors++;
      stop_test();
   end
   initial begin
      seed = 32'ha999;
      n_errors = 0;
      comparisons = 0;
      nwd = 0;
      rst_n = 1'b0;
      cv = 1'b0;
      cmd = 3'h0;
      ca = 7'h00;
      cd = 16'h0000;
      cf = 1'b0;
      strap = ADDR_SOFT;
      cexp = 16'h3C5A;
      ind = 16'h0000;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk(st, ST_POR);
      chk(sta, ADDR_SOFT);
      go(CMD_PRM, ADDR_SOFT, 16'h0202, 1'b0); chk(dok, 1'b0);
      go(CMD_SET_ADDR, ADDR_SOFT, 16'h007E, 1'b0); chk(dok, 1'b0);
      go(CMD_SET_ADDR, ADDR_SOFT, 16'h007D, 1'b0); chk(dok, 1'b1);
      @(negedge clk);
      chk(st, ST_WAIT_PRM);
      chk(sta, SA);
      $display("test address done");
      go(CMD_PRM, SA, 16'h0300, 1'b0); chk(dok, 1'b0);
      f1 = 8'(2 + ($random(seed) & 1));
      f2 = 8'(2 + ($random(seed) & 1));
      fl = 1'($random(seed));
      per = wd_per(fl, f1, f2);
      go(CMD_PRM, SA, {f1, f2}, fl); chk(dok, 1'b1);
      go(CMD_PRM, SA, 16'h0101, 1'b0); chk(dok, 1'b0);
      go(CMD_CFG, SA, ~cexp, 1'b0); chk(dok, 1'b0);
      go(CMD_DIAG, SA, 16'h0000, 1'b0); chk(ddat, diag_w(ST_WAIT_CFG, 1'b1));
      go(CMD_CFG, SA, cexp, 1'b0); chk(dok, 1'b1);
      $display("test start-up done");
      for (k = 0; k < 6; k++) begin
         ind = 16'($random(seed));
         d = 16'($random(seed));
         go(CMD_DATA, (k == 5) ? ADDR_BCAST : SA, d, 1'b0);
         if (k < 5) chk(ddat, ind);
         @(negedge clk);
         chk(outd, d);
      end
      chk(safe, 1'b0);
      $display("test data done");
      snap = nwd;
      for (k = 0; k < 4; k++) begin
         repeat (per - 8) @(negedge clk);
         go(CMD_DIAG, SA, 16'h0000, 1'b0); chk(ddat, diag_w(ST_DATA_EXCH, 1'b0));
      end
      chk(16'(nwd - snap), 16'h0000);
      k = 0;
      while (wde !== 1'b1 && k < per + 20) begin
         @(negedge clk);
         k++;
      end
      // The count starts one cycle after the restarting request; the registered expiry pulse rises on the expiry edge itself.
      chk(16'(k), 16'(per - 1));
      @(negedge clk);
      chk(outd, FS);
      chk(safe, 1'b1);
      chk(st, ST_WAIT_PRM);
      go(CMD_DATA, SA, 16'h1234, 1'b0); chk(dok, 1'b0);
      go(CMD_DIAG, 7'h10, 16'h0000, 1'b0); chk(dto, 1'b1);
      chk(dok, 1'b0);
      go(CMD_PRM, SA, 16'h0202, 1'b0); chk(dok, 1'b1);
      chk(dto, 1'b0);
      chk(rdy, 1'b1);
      $display("test watchdog done");
      // A hard strapped address skips soft addressing after a second reset.
      @(negedge clk);
      rst_n = 1'b0;
      strap = SA;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk(st, ST_WAIT_PRM);
      chk(sta, SA);
      chk(safe, 1'b1);
      go(CMD_PRM, SA, 16'h0202, 1'b0); chk(dok, 1'b1);
      $display("test strap done");
      stop_test();
   end
endmodule : fieldbus_slave_state_watchdog_tb
`default_nettype wire
